// *** rtl/iss_top.sv ***
// Shutter sequencer top: pointers, exposure timer, pixel valid, register bank
`timescale 1ns/1ps
module iss_top
   import iss_pkg::*;
(
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   // Register port
   input wire logic reg_wr_i,
   input wire logic [iss_pkg::ISS_AW-1:0] reg_addr_i,
   input wire logic [iss_pkg::ISS_DW-1:0] reg_wdata_i,
   output logic [iss_pkg::ISS_DW-1:0] reg_rdata_o,
   // Controller pulses, asynchronous pins
   input wire logic frame_start_i,
   input wire logic row_advance_i,
   input wire logic exposure_begin_i,
   input wire logic exposure_end_i,
   // Array sequencing
   output logic [10:0] read_row_o,
   output logic [10:0] reset_row_o,
   output logic row_blank_o,
   output logic column_load_o,
   output logic pixel_valid_o,
   output logic last_row_o,
   output logic global_reset_o,
   output logic global_sample_o,
   output logic timeout_o,
   output logic readout_busy_o,
   // Analog settings
   output logic rolling_mode_o,
   output logic frame_cal_slow_o,
   output logic row_cal_slow_o,
   output logic steady_column_precharge_o,
   output logic [1:0] reset_step_o,
   output logic multislope_enable_o,
   output logic external_alt_reset_select_o,
   output logic [7:0] array_config_o,
   output logic [6:0] amplifier_config_o
);
   import iss_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   logic [ISS_DW*ISS_NREG-1:0] regs;
   logic [11:0] sequencer_config;
   logic [11:0] pixel_pair_count;
   logic [11:0] row_count;
   logic [11:0] integration_time;
   logic [10:0] read_row_start;
   logic [10:0] reset_row_start;

   iss_regfile u_regs (
      .core_clk_i(core_clk_i),
      .reset_n_i(reset_n_i),
      .wr_en_i(reg_wr_i),
      .addr_i(reg_addr_i),
      .wr_data_i(reg_wdata_i),
      .rd_data_o(reg_rdata_o),
      .regs_o(regs)
   );

   function automatic logic [11:0] reg_at(input logic [3:0] idx,
                                          input logic [ISS_DW*ISS_NREG-1:0] r);
      reg_at = r[int'(idx)*ISS_DW +: ISS_DW];
   endfunction

   assign sequencer_config = reg_at(ISS_IDX_SEQ, regs);
   // Pair count beyond the array width is clamped
   assign pixel_pair_count = (reg_at(ISS_IDX_PIX, regs) > ISS_PIX_MAX) ?
                             ISS_PIX_MAX : reg_at(ISS_IDX_PIX, regs);
   assign row_count = reg_at(ISS_IDX_ROWS, regs);
   assign integration_time = reg_at(ISS_IDX_INT, regs);
   assign read_row_start = 11'(reg_at(ISS_IDX_RDROW, regs));
   assign reset_row_start = 11'(reg_at(ISS_IDX_RSTROW, regs));
   assign array_config_o = 8'(reg_at(ISS_IDX_ARRAY, regs));
   assign amplifier_config_o = 7'(reg_at(ISS_IDX_AMP, regs));

   assign rolling_mode_o = sequencer_config[ISS_B_ROLLING];
   assign frame_cal_slow_o = sequencer_config[ISS_B_FRAME_CAL];
   assign row_cal_slow_o = sequencer_config[ISS_B_ROW_CAL];
   assign steady_column_precharge_o = sequencer_config[ISS_B_PRECHARGE];
   assign reset_step_o = sequencer_config[ISS_B_STEP +: 2];
   // Multislope only takes effect in global mode
   assign multislope_enable_o = sequencer_config[ISS_B_MULTI] && !rolling_mode_o;
   assign external_alt_reset_select_o = sequencer_config[ISS_B_EXTALT];

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and edge detection
   logic [3:0] sync1;
   logic [3:0] sync2;
   logic [3:0] sync3;
   logic frame_start_p;
   logic row_adv_p;
   logic exp_begin_p;
   logic exp_end_p;

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         sync1 <= 4'h0;
         sync2 <= 4'h0;
         sync3 <= 4'h0;
      end else begin
         sync1 <= {exposure_end_i, exposure_begin_i, row_advance_i, frame_start_i};
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   assign frame_start_p = sync2[0] && !sync3[0];
   assign row_adv_p = sync2[1] && !sync3[1];
   // Exposure pins are ignored in rolling mode, where they should be low
   assign exp_begin_p = sync2[2] && !sync3[2] && !rolling_mode_o;
   assign exp_end_p = sync2[3] && !sync3[3] && !rolling_mode_o;

   ////////////////////////////////////////////////////////////////////////////
   // Row pointers and frame row counter
   logic [11:0] row_index;
   logic frame_active;

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         read_row_o <= 11'h000;
         reset_row_o <= 11'h000;
      end else if (frame_start_p) begin
         read_row_o <= read_row_start;
         // Rolling: reset pointer starts at reset_row_start plus the integration rows
         if (rolling_mode_o) begin
            reset_row_o <= reset_row_start + integration_time[10:0];
         end else begin
            reset_row_o <= reset_row_start;
         end
      end else if (row_adv_p && frame_active) begin
         read_row_o <= read_row_o + 11'h001;
         if (rolling_mode_o) begin
            reset_row_o <= reset_row_o + 11'h001;
         end
      end
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         row_index <= 12'h000;
         frame_active <= 1'b0;
         last_row_o <= 1'b0;
      end else begin
         last_row_o <= 1'b0;
         if (frame_start_p) begin
            row_index <= 12'h000;
            frame_active <= 1'b1;
         end else if (row_adv_p && frame_active) begin
            row_index <= row_index + 12'h001;
            if (row_index + 12'h001 >= row_count) begin
               frame_active <= 1'b0;
               last_row_o <= 1'b1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Row blanking on the column sequencer tick
   logic col_tick;
   logic [3:0] blank_cnt;

   iss_divider #(.BASE_LOG(ISS_COL_DIV_LOG)) u_col_div (
      .core_clk_i(core_clk_i),
      .reset_n_i(reset_n_i),
      .clear_i(row_adv_p),
      .code_i(sequencer_config[ISS_B_COLDIV +: 2]),
      .tick_o(col_tick)
   );

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         blank_cnt <= 4'h0;
         row_blank_o <= 1'b0;
         column_load_o <= 1'b0;
      end else begin
         column_load_o <= 1'b0;
         if (row_adv_p && frame_active) begin
            blank_cnt <= 4'h0;
            row_blank_o <= 1'b1;
         end else if (row_blank_o && col_tick) begin
            blank_cnt <= blank_cnt + 4'h1;
            if (blank_cnt + 4'h1 >= ISS_BLANK_TICKS) begin
               row_blank_o <= 1'b0;
               column_load_o <= 1'b1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pixel valid window after blanking
   logic [11:0] pix_cnt;

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pix_cnt <= 12'h000;
         pixel_valid_o <= 1'b0;
      end else if (column_load_o) begin
         pix_cnt <= 12'h000;
         pixel_valid_o <= 1'b1;
      end else if (pixel_valid_o) begin
         pix_cnt <= pix_cnt + 12'h001;
         if (pix_cnt >= pixel_pair_count) begin
            pixel_valid_o <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Global shutter sequencer
   typedef enum logic [3:0] {
      ISS_G_IDLE = 4'h1,
      ISS_G_EXPOSE = 4'h2,
      ISS_G_WAIT_END = 4'h4,
      ISS_G_READ = 4'h8
   } iss_gstate_e;

   iss_gstate_e gstate;
   iss_gstate_e next_gstate;
   logic glb_tick;
   logic [11:0] exp_cnt;

   iss_divider #(.BASE_LOG(ISS_GLB_DIV_LOG)) u_glb_div (
      .core_clk_i(core_clk_i),
      .reset_n_i(reset_n_i),
      .clear_i(exp_begin_p),
      .code_i(sequencer_config[ISS_B_GLBDIV +: 2]),
      .tick_o(glb_tick)
   );

   always_comb begin
      next_gstate = gstate;
      case (gstate)
         ISS_G_IDLE: begin
            if (exp_begin_p) begin
               next_gstate = ISS_G_EXPOSE;
            end
         end
         ISS_G_EXPOSE, ISS_G_WAIT_END: begin
            if (exp_end_p) begin
               next_gstate = ISS_G_READ;
            end else if (gstate == ISS_G_EXPOSE && glb_tick &&
                         exp_cnt + 12'h001 >= integration_time) begin
               next_gstate = ISS_G_WAIT_END;
            end
         end
         ISS_G_READ: begin
            // New exposure only after the stored frame is read out
            if (last_row_o) begin
               next_gstate = ISS_G_IDLE;
            end
         end
         default: next_gstate = ISS_G_IDLE;
      endcase
      if (rolling_mode_o) begin
         next_gstate = ISS_G_IDLE;
      end
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         gstate <= ISS_G_IDLE;
      end else begin
         gstate <= next_gstate;
      end
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         exp_cnt <= 12'h000;
         timeout_o <= 1'b0;
         global_reset_o <= 1'b0;
         global_sample_o <= 1'b0;
      end else begin
         timeout_o <= gstate == ISS_G_EXPOSE && next_gstate == ISS_G_WAIT_END;
         global_reset_o <= gstate == ISS_G_IDLE && next_gstate == ISS_G_EXPOSE;
         global_sample_o <= gstate != ISS_G_READ && next_gstate == ISS_G_READ;
         if (exp_begin_p) begin
            exp_cnt <= 12'h000;
         end else if (gstate == ISS_G_EXPOSE && glb_tick) begin
            exp_cnt <= exp_cnt + 12'h001;
         end
      end
   end

   assign readout_busy_o = (gstate == ISS_G_READ);

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   property p_rolling_step;
      @(posedge core_clk_i) disable iff (!reset_n_i)
      (rolling_mode_o && row_adv_p && frame_active && !frame_start_p) |=>
         (reset_row_o == $past(reset_row_o) + 11'h001);
   endproperty
   a_rolling_step: assert property (p_rolling_step) else $error("reset pointer stall");

   property p_blank_start;
      @(posedge core_clk_i) disable iff (!reset_n_i)
      (row_adv_p && frame_active) |=> row_blank_o;
   endproperty
   a_blank_start: assert property (p_blank_start) else $error("no blanking");

   property p_valid_rise;
      @(posedge core_clk_i) disable iff (!reset_n_i)
      column_load_o |=> pixel_valid_o;
   endproperty
   a_valid_rise: assert property (p_valid_rise) else $error("valid late");

   property p_valid_fall;
      @(posedge core_clk_i) disable iff (!reset_n_i)
      (pixel_valid_o && pix_cnt >= pixel_pair_count && !column_load_o) |=> !pixel_valid_o;
   endproperty
   a_valid_fall: assert property (p_valid_fall) else $error("valid stuck");

   property p_no_expose_in_read;
      @(posedge core_clk_i) disable iff (!reset_n_i)
      (gstate == ISS_G_READ) |-> !global_reset_o;
   endproperty
   a_no_expose_in_read: assert property (p_no_expose_in_read) else $error("reset in read");

   property p_timeout_once;
      @(posedge core_clk_i) disable iff (!reset_n_i)
      timeout_o |-> (exp_cnt >= integration_time) ##1 !timeout_o;
   endproperty
   a_timeout_once: assert property (p_timeout_once) else $error("bad timeout");

   property p_sample_after_end;
      @(posedge core_clk_i) disable iff (!reset_n_i)
      (exp_end_p && (gstate == ISS_G_EXPOSE || gstate == ISS_G_WAIT_END)) |=>
         ##0 global_sample_o;
   endproperty
   a_sample_after_end: assert property (p_sample_after_end) else $error("no sample");

   property p_rolling_idle;
      @(posedge core_clk_i) disable iff (!reset_n_i)
      rolling_mode_o |=> !global_reset_o;
   endproperty
   a_rolling_idle: assert property (p_rolling_idle) else $error("global in rolling");
endmodule

// *** rtl/iss_pkg.sv ***
// Shared constants for the image shutter sequencer and its register bank
package iss_pkg;
   localparam int ISS_DW = 12;
   localparam int ISS_AW = 4;
   // Register indices
   localparam logic [3:0] ISS_IDX_SEQ = 4'h0;
   localparam logic [3:0] ISS_IDX_PIX = 4'h1;
   localparam logic [3:0] ISS_IDX_ROWS = 4'h2;
   localparam logic [3:0] ISS_IDX_INT = 4'h3;
   localparam logic [3:0] ISS_IDX_COL = 4'h4;
   localparam logic [3:0] ISS_IDX_RDROW = 4'h5;
   localparam logic [3:0] ISS_IDX_RSTROW = 4'h6;
   localparam logic [3:0] ISS_IDX_ARRAY = 4'h7;
   localparam logic [3:0] ISS_IDX_AMP = 4'h8;
   localparam int ISS_NREG = 9;
   // Reset values
   localparam logic [11:0] ISS_RST_SEQ = 12'h0C4;
   localparam logic [11:0] ISS_RST_PIX = 12'h27F;
   localparam logic [11:0] ISS_RST_ROWS = 12'h3FF;
   localparam logic [11:0] ISS_RST_INT = 12'hFFF;
   localparam logic [11:0] ISS_RST_COL = 12'h000;
   localparam logic [11:0] ISS_RST_RDROW = 12'h000;
   localparam logic [11:0] ISS_RST_RSTROW = 12'h000;
   localparam logic [11:0] ISS_RST_ARRAY = 12'h000;
   localparam logic [11:0] ISS_RST_AMP = 12'h050;
   // Field widths masks
   localparam logic [11:0] ISS_MASK_11 = 12'h7FF;
   localparam logic [11:0] ISS_MASK_8 = 12'h0FF;
   localparam logic [11:0] ISS_MASK_7 = 12'h07F;
   localparam logic [11:0] ISS_PIX_MAX = 12'h280;
   // Sequencer field positions
   localparam int ISS_B_ROLLING = 0;
   localparam int ISS_B_FRAME_CAL = 1;
   localparam int ISS_B_ROW_CAL = 2;
   localparam int ISS_B_PRECHARGE = 3;
   localparam int ISS_B_COLDIV = 4;
   localparam int ISS_B_GLBDIV = 6;
   localparam int ISS_B_STEP = 8;
   localparam int ISS_B_MULTI = 10;
   localparam int ISS_B_EXTALT = 11;
   // Division log2 bases: global 32.., column 4..
   localparam int ISS_GLB_DIV_LOG = 5;
   localparam int ISS_COL_DIV_LOG = 2;
   localparam int ISS_DIV_W = 8;
   // Row blanking length in column sequencer ticks
   localparam logic [3:0] ISS_BLANK_TICKS = 4'h4;
endpackage

// *** rtl/iss_regfile.sv ***
// Configuration register bank of the shutter sequencer
`timescale 1ns/1ps
module iss_regfile
   import iss_pkg::*;
(
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   // Register port
   input wire logic wr_en_i,
   input wire logic [iss_pkg::ISS_AW-1:0] addr_i,
   input wire logic [iss_pkg::ISS_DW-1:0] wr_data_i,
   output logic [iss_pkg::ISS_DW-1:0] rd_data_o,
   // Register contents
   output logic [iss_pkg::ISS_DW*iss_pkg::ISS_NREG-1:0] regs_o
);
   import iss_pkg::*;

   logic [ISS_DW-1:0] mem [ISS_NREG];

   function automatic logic [11:0] reset_val(input int i);
      case (i)
         0: reset_val = ISS_RST_SEQ;
         1: reset_val = ISS_RST_PIX;
         2: reset_val = ISS_RST_ROWS;
         3: reset_val = ISS_RST_INT;
         4: reset_val = ISS_RST_COL;
         5: reset_val = ISS_RST_RDROW;
         6: reset_val = ISS_RST_RSTROW;
         7: reset_val = ISS_RST_ARRAY;
         default: reset_val = ISS_RST_AMP;
      endcase
   endfunction

   function automatic logic [11:0] mask_val(input int i);
      case (i)
         4, 5, 6: mask_val = ISS_MASK_11;
         7: mask_val = ISS_MASK_8;
         8: mask_val = ISS_MASK_7;
         default: mask_val = 12'hFFF;
      endcase
   endfunction

   // Every register returns to its default under reset
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         for (int i = 0; i < ISS_NREG; i++) begin
            mem[i] <= reset_val(i);
         end
      end else if (wr_en_i && (int'(addr_i) < ISS_NREG)) begin
         mem[addr_i] <= wr_data_i & mask_val(int'(addr_i));
      end
   end

   // Read data from a register; unmapped indices read zero
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rd_data_o <= 12'h000;
      end else if (int'(addr_i) < ISS_NREG) begin
         rd_data_o <= mem[addr_i];
      end else begin
         rd_data_o <= 12'h000;
      end
   end

   always_comb begin
      for (int i = 0; i < ISS_NREG; i++) begin
         regs_o[i*ISS_DW +: ISS_DW] = mem[i];
      end
   end
endmodule

// *** rtl/iss_divider.sv ***
// Programmable power-of-two tick divider
`timescale 1ns/1ps
module iss_divider
   import iss_pkg::*;
#(
   parameter int BASE_LOG = 2
) (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   // Control
   input wire logic clear_i,
   input wire logic [1:0] code_i,
   // Tick
   output logic tick_o
);
   import iss_pkg::*;

   logic [ISS_DIV_W-1:0] count;
   logic [ISS_DIV_W-1:0] limit;

   // Limit is 2**(BASE_LOG+code) - 1
   assign limit = ISS_DIV_W'((ISS_DIV_W+1)'(1) << (BASE_LOG + int'(code_i))) - 1'b1;

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         count <= '0;
      end else if (clear_i || count >= limit) begin
         count <= '0;
      end else begin
         count <= count + 1'b1;
      end
   end

   assign tick_o = !clear_i && (count >= limit);
endmodule

// *** bench/iss_ctrl_model.sv ***
// Timing controller model that drives the sensor control pins
`timescale 1ns/1ps
module iss_ctrl_model (
   // Clock and mode
   input wire logic core_clk_i,
   input wire logic rolling_mode_i,
   // Control pins
   output logic frame_start_o,
   output logic row_advance_o,
   output logic exposure_begin_o,
   output logic exposure_end_o
);
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      frame_start_o = 1'b0;
      row_advance_o = 1'b0;
      exposure_begin_o = 1'b0;
      exposure_end_o = 1'b0;
   end
   // Pins pass a two-flop synchroniser, so each level is held two cycles
   task automatic pulse(input int sel);
      @(posedge core_clk_i);
      #1;
      case (sel)
         0: frame_start_o = 1'b1;
         1: row_advance_o = 1'b1;
         2: exposure_begin_o = !rolling_mode_i;
         default: exposure_end_o = !rolling_mode_i;
      endcase
      repeat (2) @(posedge core_clk_i);
      #1;
      {frame_start_o, row_advance_o, exposure_begin_o, exposure_end_o} = 4'h0;
      repeat (2) @(posedge core_clk_i);
      #1;
   endtask
endmodule

// *** bench/iss_top_test.sv ***
// Self-checking bench for the shutter sequencer and its register bank
`timescale 1ns/1ps
module iss_top_test;
   import iss_pkg::*;
   logic core_clk_i = 1'b0;
   logic reset_n_i;
   logic reg_wr_i;
   logic [3:0] reg_addr_i;
   logic [11:0] reg_wdata_i;
   logic [11:0] reg_rdata_o, v;
   logic frame_start_i, row_advance_i, exposure_begin_i, exposure_end_i;
   logic [10:0] read_row_o, reset_row_o;
   logic row_blank_o, column_load_o, pixel_valid_o, last_row_o, global_reset_o;
   logic global_sample_o, timeout_o, readout_busy_o, rolling_mode_o, frame_cal_slow_o;
   logic row_cal_slow_o, steady_column_precharge_o, multislope_enable_o;
   logic external_alt_reset_select_o;
   logic [1:0] reset_step_o;
   logic [7:0] array_config_o;
   logic [6:0] amplifier_config_o;
   int fails = 0;
   int total_checks = 0;
   int n_grst = 0;
   int n_last = 0;
   int n;
   logic [11:0] rst_v [9] = '{ISS_RST_SEQ, ISS_RST_PIX, ISS_RST_ROWS, ISS_RST_INT, ISS_RST_COL,
      ISS_RST_RDROW, ISS_RST_RSTROW, ISS_RST_ARRAY, ISS_RST_AMP};
   logic [11:0] msk [10] = '{12'hFFF, 12'hFFF, 12'hFFF, 12'hFFF, ISS_MASK_11, ISS_MASK_11,
      ISS_MASK_11, ISS_MASK_8, ISS_MASK_7, 12'h000};
   logic [11:0] pat [2] = '{12'hFFF, 12'hA5A};

   ////////////////////////////////////////////////////////////////////////////////
   iss_top u_iss_top (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .reg_wr_i(reg_wr_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
      .frame_start_i(frame_start_i), .row_advance_i(row_advance_i),
      .exposure_begin_i(exposure_begin_i), .exposure_end_i(exposure_end_i),
      .read_row_o(read_row_o), .reset_row_o(reset_row_o), .row_blank_o(row_blank_o),
      .column_load_o(column_load_o), .pixel_valid_o(pixel_valid_o), .last_row_o(last_row_o),
      .global_reset_o(global_reset_o), .global_sample_o(global_sample_o),
      .timeout_o(timeout_o), .readout_busy_o(readout_busy_o),
      .rolling_mode_o(rolling_mode_o), .frame_cal_slow_o(frame_cal_slow_o),
      .row_cal_slow_o(row_cal_slow_o), .steady_column_precharge_o(steady_column_precharge_o),
      .reset_step_o(reset_step_o), .multislope_enable_o(multislope_enable_o),
      .external_alt_reset_select_o(external_alt_reset_select_o),
      .array_config_o(array_config_o), .amplifier_config_o(amplifier_config_o));
   iss_ctrl_model u_iss_ctrl_model (.core_clk_i(core_clk_i), .rolling_mode_i(rolling_mode_o),
      .frame_start_o(frame_start_i), .row_advance_o(row_advance_i),
      .exposure_begin_o(exposure_begin_i), .exposure_end_o(exposure_end_i));

   always #2.5 core_clk_i = ~core_clk_i;
   // Pulse counters avoid racing a one-cycle pulse against a blocking pin task
   always @(posedge core_clk_i) begin
      n_grst += (global_reset_o === 1'b1);
      n_last += (last_row_o === 1'b1);
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic check(input logic [11:0] seen, input logic [11:0] expd);
      total_checks++;
      if (seen !== expd) begin
         fails++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, expd);
      end
   endtask
   function automatic bit probe(input int sel);
      case (sel)
         0: return global_reset_o === 1'b1;
         1: return timeout_o === 1'b1;
         2: return global_sample_o === 1'b1;
         3: return row_blank_o === 1'b1;
         default: return pixel_valid_o === 1'b1;
      endcase
   endfunction
   task automatic wait_for(input int sel, input bit lvl, input int lim);
      n = 0;
      while (probe(sel) != lvl) begin
         if (n == lim) begin
            fails++;
            $display("mismatch at %0t: wait ran out", $time);
            end_of_test();
         end
         @(posedge core_clk_i);
         #1;
         n++;
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [11:0] d);
      reg_wr_i = 1'b1;
      reg_addr_i = a;
      reg_wdata_i = d;
      @(posedge core_clk_i);
      #1;
      reg_wr_i = 1'b0;
      // Let an edge pass so back to back writes never retoggle the strobe at once
      @(posedge core_clk_i);
      #1;
   endtask
   task automatic rd(input logic [3:0] a, output logic [11:0] d);
      reg_addr_i = a;
      repeat (2) @(posedge core_clk_i);
      #1;
      d = reg_rdata_o;
   endtask
   function automatic logic [11:0] seq_bits();
      return {4'h0, rolling_mode_o, frame_cal_slow_o, row_cal_slow_o, steady_column_precharge_o,
         reset_step_o, multislope_enable_o, external_alt_reset_select_o};
   endfunction
   task automatic row_cycle(input int c);
      wait_for(3, 1'b1, 20);
      wait_for(3, 1'b0, 40 << c);
      check({11'h000, n >= (13 << c) && n <= (16 << c)}, 12'h001);
      wait_for(4, 1'b1, 20);
      wait_for(4, 1'b0, 700);
      check(12'(n), 12'h004);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      reset_n_i = 1'b0;
      reg_wr_i = 1'b0;
      reg_addr_i = 4'h0;
      reg_wdata_i = 12'h000;
      repeat (16) @(posedge core_clk_i);
      #1;
      reset_n_i = 1'b1;
      for (int i = 0; i < 9; i++) begin
         rd(4'(i), v);
         check(v, rst_v[i]);
      end
      check({5'h00, amplifier_config_o}, ISS_RST_AMP);
      check(seq_bits(), 12'h020);
      for (int p = 0; p < 2; p++) begin
         for (int i = 0; i < 10; i++) wr(4'(i), pat[p]);
         for (int i = 0; i < 10; i++) begin
            rd(4'(i), v);
            check(v, pat[p] & msk[i]);
         end
      end
      check({4'h0, array_config_o}, 12'h05A);
      check({5'h00, amplifier_config_o}, 12'h05A);
      wr(ISS_IDX_SEQ, 12'hF0E);
      check(seq_bits(), 12'h07F);
      wr(ISS_IDX_SEQ, 12'h401);
      check(seq_bits(), 12'h080);
      // Rolling frame of three rows
      wr(ISS_IDX_SEQ, 12'h001);
      wr(ISS_IDX_PIX, 12'h003);
      wr(ISS_IDX_ROWS, 12'h003);
      wr(ISS_IDX_INT, 12'h005);
      wr(ISS_IDX_RDROW, 12'h00A);
      wr(ISS_IDX_RSTROW, 12'h00A);
      u_iss_ctrl_model.pulse(0);
      repeat (2) @(posedge core_clk_i);
      #1;
      check({1'b0, read_row_o}, 12'h00A);
      check({1'b0, reset_row_o}, 12'h00F);
      for (int r = 1; r <= 3; r++) begin
         fork
            u_iss_ctrl_model.pulse(1);
            row_cycle(0);
         join
         check({1'b0, read_row_o}, 12'(10 + r));
         check({1'b0, reset_row_o}, 12'(15 + r));
         check(12'(n_last), 12'((r == 3) ? 1 : 0));
      end
      u_iss_ctrl_model.pulse(1);
      repeat (30) @(posedge core_clk_i);
      #1;
      check({1'b0, read_row_o}, 12'h00D);
      // Global exposure per granularity code, then readout
      for (int c = 0; c < 4; c++) begin
         wr(ISS_IDX_SEQ, 12'((c << 6) | (c << 4)));
         wr(ISS_IDX_INT, 12'h002);
         fork
            u_iss_ctrl_model.pulse(2);
            wait_for(0, 1'b1, 20);
         join
         wait_for(1, 1'b1, 600);
         check({11'h000, n >= (32 << c) && n <= (64 << c) + 3}, 12'h001);
         fork
            u_iss_ctrl_model.pulse(3);
            wait_for(2, 1'b1, 20);
         join
         u_iss_ctrl_model.pulse(2);
         check({11'h000, readout_busy_o}, 12'h001);
         u_iss_ctrl_model.pulse(0);
         for (int r = 1; r <= 3; r++) begin
            fork
               u_iss_ctrl_model.pulse(1);
               row_cycle(c);
            join
            check({1'b0, read_row_o}, 12'(10 + r));
            check({1'b0, reset_row_o}, 12'h00A);
         end
         check({11'h000, readout_busy_o}, 12'h000);
         check(12'(n_grst), 12'(c + 1));
      end
      // Mid-run reset must bring every register back to its default
      reset_n_i = 1'b0;
      repeat (2) @(posedge core_clk_i);
      #1;
      reset_n_i = 1'b1;
      for (int i = 0; i < 9; i++) begin
         rd(4'(i), v);
         check(v, rst_v[i]);
      end
      check(seq_bits(), 12'h020);
      end_of_test();
   end
endmodule
